//--- core/mce_pkg.sv
// shared constants and carrier types for the memory controller event counters
package mce_pkg;
  localparam int NUM_CTR  = 4;
  localparam int CTR_W    = 48;
  localparam int ADDR_W   = 16;
  localparam int DATA_W   = 32;
  localparam int BE_W     = DATA_W / 8;
  localparam int RQ_DEPTH = 4;
  localparam int WQ_DEPTH = 4;
  localparam int PTR_W    = 2;
  localparam int CNT_W    = 3;
  localparam int INC_W    = 6;

  // event select codes, bits 7:0 of the control word
  localparam logic [7:0] EV_RD_RANK6   = 8'hb6;
  localparam logic [7:0] EV_RD_RANK7   = 8'hb7;
  localparam logic [7:0] EV_WR_RANK0   = 8'hb8;
  localparam logic [7:0] EV_WR_RANK1   = 8'hb9;
  localparam logic [7:0] EV_WR_RANK2   = 8'hba;
  localparam logic [7:0] EV_WR_RANK3   = 8'hbb;
  localparam logic [7:0] EV_RQ_NE      = 8'h11;
  localparam logic [7:0] EV_RQ_ALLOC   = 8'h10;
  localparam logic [7:0] EV_WQ_FULL    = 8'h22;
  localparam logic [7:0] EV_WQ_NE      = 8'h21;
  localparam logic [7:0] EV_WQ_RD_HIT  = 8'h23;
  localparam logic [7:0] EV_WQ_WR_HIT  = 8'h24;
  localparam logic [7:0] EV_BUF_PUSH   = 8'h90;
  localparam logic [7:0] EV_BUF_OCC    = 8'h91;
  localparam logic [7:0] EV_WR_TO_RD   = 8'hc0;
  localparam logic [7:0] EV_MODE_DENY  = 8'hc1;

  // bank selector in the unit mask
  localparam logic [7:0] SEL_EVERY_BANK = 8'h10;
  localparam logic [7:0] SEL_GROUP_ZERO = 8'h11;
  localparam logic [7:0] SEL_GROUP_LAST = 8'h14;

  localparam logic [2:0] RANK_SIX   = 3'h6;
  localparam logic [2:0] RANK_SEVEN = 3'h7;
  localparam logic [INC_W-1:0] MAX_OCC_INC = 6'h20;
  localparam logic [CNT_W-1:0] RQ_FULL_CNT = 3'h4;
  localparam logic [CNT_W-1:0] WQ_FULL_CNT = 3'h4;

  // counter control word: unit mask in 15:8, event select in 7:0
  typedef struct packed {
    logic [7:0] umask;
    logic [7:0] evsel;
  } mce_ctl_t;

  // request carried from the home agent, also the queue entry and column command
  typedef struct packed {
    logic              write;
    logic              isochronous_request;
    logic [2:0]        rank;
    logic [3:0]        bank;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [BE_W-1:0]   be;
  } mce_req_t;
endpackage

//--- core/mce_bank_match.sv
// decodes the column-command bank selector against one bank number
`timescale 1ns/1ps
`default_nettype none
module mce_bank_match
  import mce_pkg::*;
(
  input  wire logic [7:0] bankSel, // unit mask bank selector
  input  wire logic [3:0] bank,    // bank of the issued column command
  output logic            hit      // bank is selected
);
  logic [7:0] grp;

  always_comb begin
    grp = bankSel - SEL_GROUP_ZERO;
    if (bankSel < SEL_EVERY_BANK) begin                                   // R2
      hit = (bank == bankSel[3:0]);
    end else if (bankSel == SEL_EVERY_BANK) begin                         // R2
      hit = 1'b1;
    end else if (bankSel <= SEL_GROUP_LAST) begin                         // R2
      hit = (bank[3:2] == grp[1:0]);
    end else begin
      hit = 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- core/mce_wq_cam.sv
// address search over the live entries of the write pending queue
`timescale 1ns/1ps
`default_nettype none
module mce_wq_cam
  import mce_pkg::*;
(
  input  wire mce_req_t [WQ_DEPTH-1:0] entries, // queue storage
  input  wire logic [PTR_W-1:0]        head,    // oldest entry
  input  wire logic [CNT_W-1:0]        count,   // live entries
  input  wire logic [ADDR_W-1:0]       addr,    // address searched
  output logic                         hit,     // a live entry matches
  output logic [PTR_W-1:0]             idx      // index of the matching entry
);
  logic [WQ_DEPTH-1:0] match;

  for (genvar k = 0; k < WQ_DEPTH; k++) begin : g_ent
    logic [PTR_W-1:0] age;
    assign age      = PTR_W'(k) - head;
    assign match[k] = ({1'b0, age} < count) && (entries[k].addr == addr); // R11
  end

  // at most one live entry per address, merging keeps it so
  always_comb begin
    hit = |match;
    idx = '0;
    for (int k = 0; k < WQ_DEPTH; k++) begin
      if (match[k]) begin
        idx = PTR_W'(k);
      end
    end
  end
endmodule
`default_nettype wire

//--- core/mce_event_counters.sv
// memory controller channel queues with event-selected performance counters
//
// Function
// R1 - count read column commands to rank 6 at 0xb6, rank 7 at 0xb7, bank filtered
// R2 - bank selector 0-15 one bank, 16 all banks, 17-20 groups of four
// R3 - count write column commands to ranks 0 to 3 at 0xb8 to 0xbb
// R4 - at 0x11 count cycles the read queue holds an entry
// R5 - at 0x10 count every read queue allocation, isochronous or not
// R6 - read entry allocated on arrival, freed only once its command issues; the code also frees it when the read is forwarded from the write queue
// R7 - home agent sends a request only while holding a free-entry credit
// R8 - at 0x22 count write queue full cycles; agent sends nothing while full
// R9 - at 0x21 count cycles the write queue is not empty
// R10 - free write entry after issue; report completion when posted
// R11 - search write queue for same address before issuing any read or write
// R12 - read matching a queued write takes data from that entry
// R13 - matching full write overwrites; partial write merges its bytes, no underfill read
// R14 - count write queue matches at 0x23 and 0x24
// R15 - at 0x90 count buffer pushes; mask bit 0 write mode, bit 1 read mode
// R16 - at 0x91 add buffer occupancy, up to 32 per cycle
// R17 - at 0xc0 count write-to-read mode changes filtered by three causes
// R18 - at 0xc1 count occasions the requested major mode is refused
// R19 - other events add at most one per cycle, on any counter 0-3
// R20 - unit mask comes from control word bits 15:8
// R21 - several selected filter bits add only one when any matches
// R22 - unassigned event select leaves the counter unchanged
`timescale 1ns/1ps
`default_nettype none
module mce_event_counters
  import mce_pkg::*;
(
  input  wire logic                                 sys_clk,        // core clock
  input  wire logic                                 rst_n,          // sync reset
  input  wire logic                                 clkEn,          // freezes all state
  input  wire mce_ctl_t [NUM_CTR-1:0]               ctlWord,        // per-counter control
  input  wire logic                                 reqValid,       // home agent request
  input  wire mce_req_t                             reqData,        // request contents
  input  wire logic                                 memReady,       // memory takes a command
  input  wire logic                                 writeMajorMode, // 1 write mode, 0 read
  input  wire logic                                 bufPush,        // buffer write push
  input  wire logic [INC_W-1:0]                     bufOccupancy,   // buffer occupancy
  input  wire logic                                 modeToRead,     // write-to-read change
  input  wire logic [2:0]                           modeCause,      // threshold/starve/retry
  input  wire logic                                 modeDenied,     // requested mode refused
  output logic                                      casValid,       // column command pulse
  output mce_req_t                                  casCmd,         // column command
  output logic                                      rdRespValid,    // read served from queue
  output logic [DATA_W-1:0]                         rdRespData,     // forwarded data
  output logic                                      wrDone,         // write posted
  output logic                                      rdCredit,       // read entry freed
  output logic                                      wrCredit,       // write entry freed
  output logic                                      wqFull,         // write queue full
  output logic [NUM_CTR-1:0][CTR_W-1:0]             ctrValue        // counters
);
  typedef struct packed {
    mce_req_t [RQ_DEPTH-1:0]       rq;
    logic [PTR_W-1:0]              rqHead;
    logic [PTR_W-1:0]              rqTail;
    logic [CNT_W-1:0]              rqCnt;
    mce_req_t [WQ_DEPTH-1:0]       wq;
    logic [PTR_W-1:0]              wqHead;
    logic [PTR_W-1:0]              wqTail;
    logic [CNT_W-1:0]              wqCnt;
    logic                          casValid;
    mce_req_t                      cas;
    logic                          rdRespValid;
    logic [DATA_W-1:0]             rdRespData;
    logic                          wrDone;
    logic                          rdCredit;
    logic                          wrCredit;
    logic                          wqFull;
    logic [NUM_CTR-1:0][CTR_W-1:0] ctr;
  } mce_state_t;

  mce_state_t stFf;
  mce_state_t nxt_stFf;

  logic                           rdHit;
  logic [PTR_W-1:0]               rdIdx;
  logic                           wrHit;
  logic [PTR_W-1:0]               wrIdx;
  logic                           wrReq;
  logic                           wrMerge;
  logic                           wqPush;
  logic                           rqPush;
  logic                           rdHitTake;
  logic                           rdIssue;
  logic                           wrIssue;
  mce_req_t                       casNow;
  mce_req_t                       merged;
  logic [NUM_CTR-1:0][INC_W-1:0]  incV;
  logic [NUM_CTR-1:0]             evKnown;

  // search for the read at the head of its queue, and for an arriving write
  mce_wq_cam u_rd_cam (
    .entries (stFf.wq),
    .head    (stFf.wqHead),
    .count   (stFf.wqCnt),
    .addr    (stFf.rq[stFf.rqHead].addr),
    .hit     (rdHit),
    .idx     (rdIdx)
  );

  mce_wq_cam u_wr_cam (
    .entries (stFf.wq),
    .head    (stFf.wqHead),
    .count   (stFf.wqCnt),
    .addr    (reqData.addr),
    .hit     (wrHit),
    .idx     (wrIdx)
  );

  always_comb begin
    wrReq     = reqValid && reqData.write;
    wrMerge   = wrReq && wrHit;                                           // R13
    wqPush    = wrReq && !wrHit && (stFf.wqCnt != WQ_FULL_CNT);           // R8
    rqPush    = reqValid && !reqData.write && (stFf.rqCnt != RQ_FULL_CNT); // R6
    rdHitTake = (stFf.rqCnt != '0) && rdHit;                              // R12
    rdIssue   = (stFf.rqCnt != '0) && !rdHit && memReady;                 // R11
    // reads go ahead of writes; a write head being merged this cycle waits
    wrIssue   = (stFf.rqCnt == '0) && (stFf.wqCnt != '0) && memReady &&
                !(wrMerge && (wrIdx == stFf.wqHead));                     // R11
    casNow    = rdIssue ? stFf.rq[stFf.rqHead] : stFf.wq[stFf.wqHead];
    merged    = stFf.wq[wrIdx];
    for (int b = 0; b < BE_W; b++) begin
      if (reqData.be[b]) begin                                            // R13
        merged.data[8*b +: 8] = reqData.data[8*b +: 8];
      end
    end
    merged.be = merged.be | reqData.be;
  end

  // event selection, one set of logic per counter
  for (genvar i = 0; i < NUM_CTR; i++) begin : g_ctr
    logic [7:0] ev;
    logic [7:0] um;
    logic       bankOk;

    assign ev = ctlWord[i].evsel;
    assign um = ctlWord[i].umask;                                         // R20

    mce_bank_match u_bank (
      .bankSel (um),
      .bank    (casNow.bank),
      .hit     (bankOk)
    );

    always_comb begin
      incV[i]    = '0;
      evKnown[i] = 1'b1;
      case (ev)
        EV_RD_RANK6: begin                                                // R1
          incV[i] = INC_W'(rdIssue && casNow.rank == RANK_SIX && bankOk);
        end
        EV_RD_RANK7: begin                                                // R1
          incV[i] = INC_W'(rdIssue && casNow.rank == RANK_SEVEN && bankOk);
        end
        EV_WR_RANK0, EV_WR_RANK1, EV_WR_RANK2, EV_WR_RANK3: begin         // R3
          incV[i] = INC_W'(wrIssue && casNow.rank == {1'b0, ev[1:0]} && bankOk);
        end
        EV_RQ_NE: begin                                                   // R4
          incV[i] = INC_W'(stFf.rqCnt != '0);
        end
        EV_RQ_ALLOC: begin                                                // R5
          incV[i] = INC_W'(rqPush);
        end
        EV_WQ_FULL: begin                                                 // R8
          incV[i] = INC_W'(stFf.wqCnt == WQ_FULL_CNT);
        end
        EV_WQ_NE: begin                                                   // R9
          incV[i] = INC_W'(stFf.wqCnt != '0);
        end
        EV_WQ_RD_HIT: begin                                               // R14
          incV[i] = INC_W'(rdHitTake);
        end
        EV_WQ_WR_HIT: begin                                               // R14
          incV[i] = INC_W'(wrMerge);
        end
        EV_BUF_PUSH: begin                                                // R15 R21
          incV[i] = INC_W'(bufPush && ((um[0] && writeMajorMode) ||
                                       (um[1] && !writeMajorMode)));
        end
        EV_BUF_OCC: begin                                                 // R16
          incV[i] = (bufOccupancy > MAX_OCC_INC) ? MAX_OCC_INC : bufOccupancy;
        end
        EV_WR_TO_RD: begin                                                // R17 R21
          incV[i] = INC_W'(modeToRead && |(um[2:0] & modeCause));
        end
        EV_MODE_DENY: begin                                               // R18
          incV[i] = INC_W'(modeDenied);
        end
        default: begin                                                    // R22
          incV[i]    = '0;
          evKnown[i] = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    nxt_stFf             = stFf;
    nxt_stFf.casValid    = 1'b0;
    nxt_stFf.rdRespValid = 1'b0;
    nxt_stFf.wrDone      = 1'b0;
    nxt_stFf.rdCredit    = 1'b0;
    nxt_stFf.wrCredit    = 1'b0;
    // read queue: allocate on arrival, free on issue or forward
    if (rqPush) begin                                                     // R6
      nxt_stFf.rq[stFf.rqTail] = reqData;
      nxt_stFf.rqTail          = stFf.rqTail + 2'h1;
    end
    if (rdHitTake) begin                                                  // R12
      nxt_stFf.rdRespValid = 1'b1;
      nxt_stFf.rdRespData  = stFf.wq[rdIdx].data;
    end
    if (rdHitTake || rdIssue) begin                                       // R6
      nxt_stFf.rqHead   = stFf.rqHead + 2'h1;
      nxt_stFf.rdCredit = 1'b1;
    end
    nxt_stFf.rqCnt = stFf.rqCnt + CNT_W'(rqPush) - CNT_W'(rdHitTake || rdIssue);
    // write queue: merge or post, completion reported at posting
    if (wrMerge) begin                                                    // R13
      nxt_stFf.wq[wrIdx] = merged;
    end
    if (wqPush) begin
      nxt_stFf.wq[stFf.wqTail] = reqData;
      nxt_stFf.wqTail          = stFf.wqTail + 2'h1;
    end
    nxt_stFf.wrDone = wrMerge || wqPush;                                  // R10
    if (wrIssue) begin                                                    // R10
      nxt_stFf.wqHead   = stFf.wqHead + 2'h1;
      nxt_stFf.wrCredit = 1'b1;
    end
    nxt_stFf.wqCnt  = stFf.wqCnt + CNT_W'(wqPush) - CNT_W'(wrIssue);
    nxt_stFf.wqFull = (nxt_stFf.wqCnt == WQ_FULL_CNT);                    // R8
    if (rdIssue || wrIssue) begin
      nxt_stFf.casValid = 1'b1;
      nxt_stFf.cas      = casNow;
    end
    for (int k = 0; k < NUM_CTR; k++) begin                               // R19
      nxt_stFf.ctr[k] = stFf.ctr[k] + CTR_W'(incV[k]);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stFf <= '0;
    end else if (clkEn) begin
      stFf <= nxt_stFf;
    end
  end

  assign casValid    = stFf.casValid;
  assign casCmd      = stFf.cas;
  assign rdRespValid = stFf.rdRespValid;
  assign rdRespData  = stFf.rdRespData;
  assign wrDone      = stFf.wrDone;
  assign rdCredit    = stFf.rdCredit;
  assign wrCredit    = stFf.wrCredit;
  assign wqFull      = stFf.wqFull;
  assign ctrValue    = stFf.ctr;

  // checks, all on counter 0 and the queues
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_rq_ne_count;
    clkEn && ctlWord[0].evsel == EV_RQ_NE && stFf.rqCnt != '0
      |=> ctrValue[0] == $past(ctrValue[0]) + 48'h0000_0000_0001;
  endproperty
  a_rq_ne_count: assert property (p_rq_ne_count) // R4
    else $error("read queue busy cycle not counted");

  property p_unknown_frozen;
    clkEn && !evKnown[0] |=> $stable(ctrValue[0]);
  endproperty
  a_unknown_frozen: assert property (p_unknown_frozen) // R22
    else $error("counter moved on an unassigned event");

  property p_rq_keeps;
    clkEn && !rdIssue && !rdHitTake |=> stFf.rqCnt >= $past(stFf.rqCnt);
  endproperty
  a_rq_keeps: assert property (p_rq_keeps) // R6
    else $error("read entry freed without issue");

  property p_posted_done;
    clkEn && wrReq && !wqFull
      |=> wrDone ##1 (!wrDone || $past(wrReq) || !$past(clkEn));
  endproperty
  a_posted_done: assert property (p_posted_done) // R10
    else $error("posted write not reported");

  property p_forward;
    clkEn && rdHitTake |=> rdRespValid && !casValid;
  endproperty
  a_forward: assert property (p_forward) // R12
    else $error("matched read went to memory");

  property p_occ_bound;
    clkEn && ctlWord[0].evsel == EV_BUF_OCC
      |=> ctrValue[0] - $past(ctrValue[0]) <= 48'h0000_0000_0020;
  endproperty
  a_occ_bound: assert property (p_occ_bound) // R16
    else $error("occupancy step above 32");

  property p_single_step;
    clkEn && ctlWord[0].evsel != EV_BUF_OCC
      |=> ctrValue[0] - $past(ctrValue[0]) <= 48'h0000_0000_0001;
  endproperty
  a_single_step: assert property (p_single_step) // R19
    else $error("event stepped by more than one");

  property p_full_count;
    clkEn && ctlWord[0].evsel == EV_WQ_FULL && wqFull
      |=> ctrValue[0] == $past(ctrValue[0]) + 48'h0000_0000_0001;
  endproperty
  a_full_count: assert property (p_full_count) // R8
    else $error("full cycle not counted");

  property p_merge_no_alloc;
    clkEn && wrMerge && !wrIssue |=> stFf.wqCnt == $past(stFf.wqCnt);
  endproperty
  a_merge_no_alloc: assert property (p_merge_no_alloc) // R13
    else $error("matching write took a new entry");
endmodule
`default_nettype wire

//--- bench/mce_home_agent.sv
// home agent model: sends a request only while it holds a queue credit
`timescale 1ns/1ps
`default_nettype none
module mce_home_agent
  import mce_pkg::*;
(
  input  wire logic     sys_clk,  // core clock
  input  wire logic     rst_n,    // sync reset
  input  wire logic     cmdValid, // bench asks for a request
  input  wire mce_req_t cmd,      // request to send
  input  wire logic     rdCredit, // read entry freed
  input  wire logic     wrCredit, // write entry freed
  input  wire logic     wqFull,   // write queue full
  output logic          reqValid, // request to the controller
  output mce_req_t      reqData   // request contents
);
  int   rdCr;
  int   wrCr;
  logic ok;
  // without a credit the request is dropped, as a real agent would hold it
  assign ok = !wqFull && (cmd.write ? (wrCr > 0) : (rdCr > 0));
  assign reqValid = cmdValid && ok;
  // idle lines carry the inverse so a stale request never looks fresh
  assign reqData = reqValid ? cmd : ~cmd;
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      rdCr <= RQ_DEPTH;
      wrCr <= WQ_DEPTH;
    end else begin
      rdCr <= rdCr + int'(rdCredit) - int'(reqValid && !cmd.write);
      wrCr <= wrCr + int'(wrCredit) - int'(reqValid && cmd.write);
    end
  end
endmodule
`default_nettype wire

//--- bench/mce_event_counters_tb.sv
// self-checking bench for the memory controller event counters
`timescale 1ns/1ps
`default_nettype none
module mce_event_counters_tb;
  import mce_pkg::*;
  logic sys_clk, rst_n, clkEn, memReady, writeMajorMode, bufPush;
  logic modeToRead, modeDenied, cmdValid, reqValid, casValid;
  logic rdRespValid, wrDone, rdCredit, wrCredit, wqFull;
  logic [INC_W-1:0] bufOccupancy;
  logic [2:0] modeCause;
  logic [DATA_W-1:0] rdRespData, lastResp, d1, d2;
  mce_ctl_t [NUM_CTR-1:0] ctlWord;
  mce_req_t cmd, reqData, casCmd;
  mce_req_t casQ[$];
  logic [NUM_CTR-1:0][CTR_W-1:0] ctrValue;
  logic [CTR_W-1:0] expC[NUM_CTR];
  logic [7:0] sel[NUM_CTR];
  logic [7:0] codes[6] = '{EV_RD_RANK6, EV_RD_RANK7, EV_WR_RANK0,
                           EV_WR_RANK1, EV_WR_RANK2, EV_WR_RANK3};
  logic [3:0] bk, be2;
  logic r;
  int n_mismatch, comparisons, nRdCr, nWrCr, nDone, nResp;

  mce_event_counters i_mce_event_counters (.sys_clk(sys_clk), .rst_n(rst_n),
    .clkEn(clkEn), .ctlWord(ctlWord), .reqValid(reqValid), .reqData(reqData),
    .memReady(memReady), .writeMajorMode(writeMajorMode), .bufPush(bufPush),
    .bufOccupancy(bufOccupancy), .modeToRead(modeToRead), .modeCause(modeCause),
    .modeDenied(modeDenied), .casValid(casValid), .casCmd(casCmd),
    .rdRespValid(rdRespValid), .rdRespData(rdRespData), .wrDone(wrDone),
    .rdCredit(rdCredit), .wrCredit(wrCredit), .wqFull(wqFull), .ctrValue(ctrValue));
  mce_home_agent i_mce_home_agent (.sys_clk(sys_clk), .rst_n(rst_n),
    .cmdValid(cmdValid), .cmd(cmd), .rdCredit(rdCredit), .wrCredit(wrCredit),
    .wqFull(wqFull), .reqValid(reqValid), .reqData(reqData));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // one-cycle answers are caught at the edge where they stand
  always @(posedge sys_clk) begin
    if (rst_n === 1'b1 && clkEn === 1'b1) begin
      if (casValid === 1'b1) casQ.push_back(casCmd);
      if (rdCredit === 1'b1) nRdCr++;
      if (wrCredit === 1'b1) nWrCr++;
      if (wrDone === 1'b1) nDone++;
      if (rdRespValid === 1'b1) begin
        nResp++;
        lastResp = rdRespData;
      end
    end
  end

  task automatic chk(input string what, input logic [CTR_W-1:0] e, got);
    comparisons++;
    if (got !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", what, e, got);
    end
  endtask
  task automatic chkFlag(input string what, input logic e, got);
    comparisons++;
    if (got !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", what, e, got);
    end
  endtask
  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic doReset();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    cmdValid <= 1'b0;
    memReady <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    casQ.delete();
    {nRdCr, nWrCr, nDone, nResp} = '0;
  endtask
  task automatic send(input mce_req_t q);
    @(posedge sys_clk);
    cmdValid <= 1'b1;
    cmd <= q;
    @(posedge sys_clk);
    cmdValid <= 1'b0;
  endtask
  function automatic mce_req_t mk(logic w, logic [2:0] rk, logic [3:0] b,
      logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d, logic [BE_W-1:0] m);
    return {w, 1'($urandom), rk, b, a, d, m};
  endfunction
  function automatic logic bankHit(logic [7:0] s, logic [3:0] b);
    if (s < SEL_EVERY_BANK) return b == s[3:0];
    if (s == SEL_EVERY_BANK) return 1'b1;
    if (s <= SEL_GROUP_LAST) return b[3:2] == 2'(s - SEL_GROUP_ZERO);
    return 1'b0;
  endfunction
  function automatic logic [DATA_W-1:0] merge(logic [DATA_W-1:0] o, n,
      logic [BE_W-1:0] m);
    for (int i = 0; i < BE_W; i++) if (m[i]) o[8*i+:8] = n[8*i+:8];
    return o;
  endfunction

  initial begin
    {rst_n, clkEn, memReady, writeMajorMode, bufPush, cmdValid} = 6'h10;
    {modeToRead, modeDenied, modeCause, bufOccupancy} = '0;
    cmd = '0;
    ctlWord = '0;
    void'($urandom(24));
    // one column command per code, four bank selectors side by side
    for (int k = 0; k < 6; k++) begin
      doReset();
      memReady <= 1'b1;
      bk = 4'($urandom);
      sel = '{{4'h0, bk}, SEL_EVERY_BANK, 8'(17 + $urandom % 4), 8'($urandom % 21)};
      for (int j = 0; j < NUM_CTR; j++) ctlWord[j] <= {sel[j], codes[k]};
      send(mk(k > 1, 3'(k < 2 ? 6 + k : k - 2), bk, 16'($urandom), 32'($urandom), 4'hf));
      wt(6);
      for (int j = 0; j < NUM_CTR; j++)
        chk("bank counter", CTR_W'(bankHit(sel[j], bk)), ctrValue[j]);
      chk("issued commands", 1, CTR_W'(casQ.size()));
    end
    // queues held by a stalled memory: occupancy events
    doReset();
    ctlWord <= {8'($urandom), EV_WQ_NE, 8'($urandom), EV_RQ_ALLOC,
                8'($urandom), EV_WQ_FULL, 8'($urandom), EV_RQ_NE};
    // reads go first: the agent may send nothing once the write queue is full
    for (int i = 0; i < 2; i++) send(mk(0, 3'(i), 4'(i), 16'h0200 + 16'(i), 32'h0, 4'hf));
    for (int i = 0; i < 4; i++) send(mk(1, 3'(i), 4'(i), 16'h0100 + 16'(i), 32'($urandom), 4'hf));
    send(mk(1, 3'h0, 4'h0, 16'h0300, 32'($urandom), 4'hf));
    wt(2);
    chkFlag("queue full", 1'b1, wqFull);
    chk("read credits early", 0, CTR_W'(nRdCr));
    chk("posted writes", 4, CTR_W'(nDone));
    chk("read allocations", 2, ctrValue[2]);
    for (int j = 0; j < NUM_CTR; j++) expC[j] = ctrValue[j];
    wt(10);
    chk("read nonempty cycles", expC[0] + 10, ctrValue[0]);
    chk("write full cycles", expC[1] + 10, ctrValue[1]);
    chk("write nonempty cycles", expC[3] + 10, ctrValue[3]);
    // counter 0 moves onto the full event so its checker sees a full queue
    @(posedge sys_clk);
    ctlWord[0] <= {8'h00, EV_WQ_FULL};
    #1;
    expC[0] = ctrValue[0];
    wt(5);
    chk("full cycles on counter 0", expC[0] + 5, ctrValue[0]);
    @(posedge sys_clk);
    memReady <= 1'b1;
    wt(20);
    chk("issued commands", 6, CTR_W'(casQ.size()));
    for (int i = 0; i < 6 && i < casQ.size(); i++)
      chkFlag("issue order", i > 1, casQ[i].write);
    chk("read credits", 2, CTR_W'(nRdCr));
    chk("write credits", 4, CTR_W'(nWrCr));
    // address matches: merge then forward
    doReset();
    ctlWord <= {8'($urandom), EV_WQ_WR_HIT, 8'($urandom), EV_WQ_RD_HIT,
                8'hff, 8'h5a, 8'($urandom), 8'h55};
    d1 = $urandom;
    d2 = $urandom;
    be2 = 4'(1 + $urandom % 14);
    send(mk(1, 3'h1, 4'h2, 16'h0a5a, d1, 4'hf));
    send(mk(1, 3'h1, 4'h2, 16'h0a5a, d2, be2));
    send(mk(0, 3'h1, 4'h2, 16'h0a5a, 32'h0, 4'hf));
    wt(4);
    chk("forwarded reads", 1, CTR_W'(nResp));
    chk("forwarded data", CTR_W'(merge(d1, d2, be2)), CTR_W'(lastResp));
    chk("memory commands", 0, CTR_W'(casQ.size()));
    chk("read matches", 1, ctrValue[2]);
    chk("write matches", 1, ctrValue[3]);
    chk("unassigned code", 0, ctrValue[1]);
    chk("unassigned code", 0, ctrValue[0]);
    @(posedge sys_clk);
    memReady <= 1'b1;
    wt(8);
    chk("merged issues", 1, CTR_W'(casQ.size()));
    if (casQ.size() > 0)
      chk("merged data", CTR_W'(merge(d1, d2, be2)), CTR_W'(casQ[0].data));
    // random mode and buffer traffic, with the clock enable dropping
    doReset();
    ctlWord <= {8'($urandom), EV_MODE_DENY, 8'($urandom % 8), EV_WR_TO_RD,
                8'($urandom % 4), EV_BUF_PUSH, 8'($urandom), EV_BUF_OCC};
    expC = '{default: '0};
    for (int i = 0; i <= 300; i++) begin
      @(posedge sys_clk);
      if (clkEn && rst_n) begin
        expC[1] += bufPush && (writeMajorMode ? ctlWord[1].umask[0] : ctlWord[1].umask[1]);
        expC[0] += (bufOccupancy > 32) ? 32 : bufOccupancy;
        expC[2] += modeToRead && |(ctlWord[2].umask[2:0] & modeCause);
        expC[3] += modeDenied;
      end
      r = (i < 300);
      clkEn <= !r || ($urandom % 8 != 0);
      {writeMajorMode, bufPush, modeToRead, modeDenied} <= r ? 4'($urandom) : 4'h0;
      bufOccupancy <= r ? 6'($urandom) : 6'h00;
      modeCause <= r ? 3'($urandom) : 3'h0;
    end
    wt(2);
    chk("push counter", expC[1], ctrValue[1]);
    chk("occupancy counter", expC[0], ctrValue[0]);
    chk("mode change counter", expC[2], ctrValue[2]);
    chk("mode denied counter", expC[3], ctrValue[3]);
    results();
  end

  // whole run is under a thousand cycles; this leaves wide margin
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    results();
  end
endmodule
`default_nettype wire
